// ===== verilog/ugt_pkg.sv
// Shared constants and carrier types of the UI frame and TEI gate
package ugt_pkg;
	localparam logic [6:0] TEI_GROUP   = 7'h7f;
	localparam logic [6:0] TEI_RST     = 7'h00;
	localparam logic [5:0] SAPI_MGMT   = 6'h3f;
	localparam logic [5:0] SAPI_CALL   = 6'h00;
	localparam logic [5:0] SAPI_PKT    = 6'h10;
	localparam logic       CR_USER_CMD = 1'b0;
	localparam logic       CR_USER_RSP = 1'b1;
	localparam logic       CR_NET_CMD  = 1'b1;
	localparam logic       PF_UI       = 1'b0;
	localparam int         FIFO_AW     = 2;
	localparam logic [2:0] FIFO_DEPTH  = 3'h4;
	localparam logic [7:0] U_PF_MASK   = 8'hef;
	localparam logic [1:0] S_FMT       = 2'h1;
	localparam logic [7:0] CTL_UI      = 8'h03;
	localparam logic [7:0] CTL_SABME   = 8'h6f;
	localparam logic [7:0] CTL_DISC    = 8'h43;
	localparam logic [7:0] CTL_UA      = 8'h63;
	localparam logic [7:0] CTL_DM      = 8'h0f;
	localparam logic [7:0] CTL_FRMR    = 8'h87;
	localparam logic [7:0] CTL_XID     = 8'haf;
	localparam logic [7:0] CTL_RR      = 8'h01;
	localparam logic [7:0] CTL_RNR     = 8'h05;
	localparam logic [7:0] CTL_REJ     = 8'h09;

	typedef enum logic [3:0] {
		FK_OTHER, FK_UI, FK_SABME, FK_DISC, FK_UA, FK_DM, FK_FRMR,
		FK_XID, FK_I, FK_RR, FK_RNR, FK_REJ
	} ugt_fkind_t;

	typedef enum logic [2:0] {RK_RR, RK_RNR, RK_REJ, RK_UA, RK_DM} ugt_rkind_t;

	typedef struct packed {
		logic [5:0]  sapi;
		logic        cr;
		logic [6:0]  tei;
		logic [15:0] ctl;
		logic [7:0]  info;
	} ugt_frame_t;

	typedef struct packed {
		logic       valid;
		ugt_frame_t frame;
	} ugt_ph_t;

	typedef struct packed {
		logic       valid;
		logic       bcast;
		logic [5:0] sapi;
		logic [7:0] info;
	} ugt_ui_req_t;

	typedef struct packed {
		logic       bcast;
		logic [5:0] sapi;
		logic [7:0] info;
	} ugt_ui_ent_t;

	typedef struct packed {
		logic       valid;
		logic [5:0] sapi;
		logic [7:0] info;
	} ugt_ui_ind_t;

	typedef struct packed {
		logic       valid;
		ugt_rkind_t kind;
		logic [6:0] nr;
		logic [5:0] sapi;
	} ugt_rsp_req_t;

	typedef struct packed {
		logic       valid;
		ugt_fkind_t kind;
		logic       pf;
		logic       cmd;
		ugt_frame_t frame;
	} ugt_rx_t;
endpackage

// ===== verilog/ugt_ui_fifo.sv
// Small in-order queue of pending UI transfer requests
`timescale 1ns/1ps
module ugt_ui_fifo (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire ugt_pkg::ugt_ui_req_t push,
	output logic                      in_ready,
	input  wire logic                 pop,
	input  wire logic                 flush,
	output logic                      head_valid,
	output ugt_pkg::ugt_ui_ent_t      head
);
	import ugt_pkg::*;

	typedef struct packed {
		ugt_ui_ent_t [(1<<FIFO_AW)-1:0] mem;
		logic [FIFO_AW-1:0]             wp;
		logic [FIFO_AW-1:0]             rp;
		logic [2:0]                     cnt;
		logic                           nfull;
	} ugt_fifo_st_t;

	ugt_fifo_st_t st_q;
	ugt_fifo_st_t st_d;
	logic         do_push;
	logic         do_pop;

	always_comb begin
		st_d = st_q;
		do_push = push.valid && st_q.nfull;
		do_pop = pop && (st_q.cnt != 3'h0);
		if (flush) begin
			st_d.wp = '0;
			st_d.rp = '0;
			st_d.cnt = 3'h0;
		end else begin
			if (do_push) begin
				st_d.mem[st_q.wp] = {push.bcast, push.sapi, push.info};
				st_d.wp = st_q.wp + 2'h1;
			end
			if (do_pop)
				st_d.rp = st_q.rp + 2'h1;
			if (do_push && !do_pop)
				st_d.cnt = st_q.cnt + 3'h1;
			else if (!do_push && do_pop)
				st_d.cnt = st_q.cnt - 3'h1;
		end
		st_d.nfull = (st_d.cnt != FIFO_DEPTH);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			st_q <= '{nfull: 1'b1, default: '0};
		else
			st_q <= st_d;
	end

	assign in_ready = st_q.nfull;
	assign head_valid = (st_q.cnt != 3'h0);
	assign head = st_q.mem[st_q.rp];
endmodule

// ===== verilog/ugt_rx_decode.sv
// Classifies received frames by control field and poll/final bit
`timescale 1ns/1ps
module ugt_rx_decode (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire ugt_pkg::ugt_ph_t rx_in,
	output ugt_pkg::ugt_rx_t      rx_out
);
	import ugt_pkg::*;

	ugt_rx_t st_q;
	ugt_rx_t st_d;

	always_comb begin
		st_d.valid = rx_in.valid;
		st_d.frame = rx_in.frame;
		st_d.cmd = (rx_in.frame.cr == CR_NET_CMD);
		st_d.kind = FK_OTHER;
		st_d.pf = rx_in.frame.ctl[8];
		if (!rx_in.frame.ctl[0]) begin
			st_d.kind = FK_I;
		end else if (rx_in.frame.ctl[1:0] == S_FMT) begin
			case (rx_in.frame.ctl[7:0])
				CTL_RR:  st_d.kind = FK_RR;
				CTL_RNR: st_d.kind = FK_RNR;
				CTL_REJ: st_d.kind = FK_REJ;
				default: st_d.kind = FK_OTHER;
			endcase
		end else begin
			st_d.pf = rx_in.frame.ctl[4];
			case (rx_in.frame.ctl[7:0] & U_PF_MASK)
				CTL_UI:    st_d.kind = FK_UI;
				CTL_SABME: st_d.kind = FK_SABME;
				CTL_DISC:  st_d.kind = FK_DISC;
				CTL_UA:    st_d.kind = FK_UA;
				CTL_DM:    st_d.kind = FK_DM;
				CTL_FRMR:  st_d.kind = FK_FRMR;
				CTL_XID:   st_d.kind = FK_XID;
				default:   st_d.kind = FK_OTHER;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign rx_out = st_q;
endmodule

// ===== verilog/ugt_core.sv
// Unacknowledged transfer and TEI gate of the user-side data link entity
`timescale 1ns/1ps
module ugt_core (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire ugt_pkg::ugt_ui_req_t l3_req,
	output logic                      l3_req_ready,
	input  wire ugt_pkg::ugt_ui_req_t mg_req,
	output logic                      mg_req_ready,
	input  wire logic                 est_req,
	output logic                      est_go,
	output logic                      rel_ind,
	input  wire logic                 assign_req,
	input  wire logic [6:0]           assign_tei,
	input  wire logic                 remove_req,
	input  wire logic                 error_rsp,
	output logic                      assign_ind,
	input  wire ugt_pkg::ugt_rsp_req_t rsp_req,
	output logic                      rsp_ready,
	input  wire ugt_pkg::ugt_ph_t     ph_rx,
	input  wire logic                 ph_deact_ind,
	output ugt_pkg::ugt_ph_t          ph_tx,
	input  wire logic                 ph_tx_ready,
	output ugt_pkg::ugt_ui_ind_t      l3_ind,
	output ugt_pkg::ugt_ui_ind_t      mg_ind,
	output logic                      frmr_ind,
	output logic                      final_due,
	output logic                      tei_assigned,
	output logic [6:0]                tei_value
);
	import ugt_pkg::*;

	typedef struct packed {
		logic         tei_ok;
		logic [6:0]   tei;
		logic         asked;
		logic         est_pend;
		logic         fin_due;
		logic         fin_u;
		ugt_rsp_req_t rsp;
		logic         rsp_ready;
		ugt_ph_t      tx;
		ugt_ui_ind_t  l3_ind;
		ugt_ui_ind_t  mg_ind;
		logic         frmr_ind;
		logic         est_go;
		logic         rel_ind;
		logic         assign_ind;
	} ugt_core_st_t;

	ugt_core_st_t st_q;
	ugt_core_st_t st_d;
	ugt_rx_t      rx;
	ugt_ui_ent_t  l3_head;
	ugt_ui_ent_t  mg_head;
	logic         l3_head_v;
	logic         mg_head_v;
	logic         l3_pop;
	logic         mg_pop;
	logic         l3_flush;
	logic         mg_flush;
	logic         l3_rdy;
	logic         mg_rdy;
	logic         need_tei;
	logic         to_us;
	logic         polled;

	// UI command frame, P bit held at zero
	function automatic ugt_frame_t ui_frame(
		input logic [5:0] sapi,
		input logic [6:0] tei,
		input logic [7:0] info
	);
		ugt_frame_t fr;
		fr.sapi = sapi;
		fr.cr = CR_USER_CMD;
		fr.tei = tei;
		fr.ctl = {8'h00, CTL_UI[7:5], PF_UI, CTL_UI[3:0]};
		fr.info = info;
		return fr;
	endfunction

	// Response frame, F bit and kind tied to the pending poll
	function automatic ugt_frame_t rsp_frame(
		input ugt_rsp_req_t r,
		input logic         f,
		input logic         fu,
		input logic [6:0]   tei
	);
		ugt_frame_t fr;
		ugt_rkind_t k;
		k = r.kind;
		if (f && fu && !(k == RK_UA || k == RK_DM))
			k = RK_DM;
		else if (f && !fu && (k == RK_UA || k == RK_DM))
			k = RK_RR;
		fr.sapi = r.sapi;
		fr.cr = CR_USER_RSP;
		fr.tei = tei;
		fr.info = 8'h00;
		// FRMR is not among the kinds that can be built
		case (k)
			RK_RR:   fr.ctl = {r.nr, f, CTL_RR};
			RK_RNR:  fr.ctl = {r.nr, f, CTL_RNR};
			RK_REJ:  fr.ctl = {r.nr, f, CTL_REJ};
			RK_UA:   fr.ctl = {8'h00, CTL_UA[7:5], f, CTL_UA[3:0]};
			default: fr.ctl = {8'h00, CTL_DM[7:5], f, CTL_DM[3:0]};
		endcase
		return fr;
	endfunction

	ugt_rx_decode u_rx (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.rx_in  (ph_rx),
		.rx_out (rx)
	);

	ugt_ui_fifo u_l3q (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.push       (l3_req),
		.in_ready   (l3_rdy),
		.pop        (l3_pop),
		.flush      (l3_flush),
		.head_valid (l3_head_v),
		.head       (l3_head)
	);

	ugt_ui_fifo u_mgq (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.push       (mg_req),
		.in_ready   (mg_rdy),
		.pop        (mg_pop),
		.flush      (mg_flush),
		.head_valid (mg_head_v),
		.head       (mg_head)
	);

	always_comb begin
		st_d = st_q;
		st_d.l3_ind.valid = 1'b0;
		st_d.mg_ind.valid = 1'b0;
		st_d.frmr_ind = 1'b0;
		st_d.est_go = 1'b0;
		st_d.rel_ind = 1'b0;
		st_d.assign_ind = 1'b0;
		l3_pop = 1'b0;
		mg_pop = 1'b0;
		l3_flush = ph_deact_ind;
		mg_flush = ph_deact_ind;
		need_tei = 1'b0;
		to_us = 1'b0;
		polled = 1'b0;

		// Physical layer takes the frame on ready
		if (st_q.tx.valid && ph_tx_ready)
			st_d.tx.valid = 1'b0;
		// A UI frame still waiting is discarded too
		if (ph_deact_ind && st_q.tx.frame.ctl[7:0] == CTL_UI)
			st_d.tx.valid = 1'b0;

		// Transmit slot: response, then management, then layer 3
		if (!st_d.tx.valid) begin
			if (st_q.rsp.valid) begin
				st_d.tx.valid = 1'b1;
				st_d.tx.frame = rsp_frame(st_q.rsp, st_q.fin_due,
					st_q.fin_u, st_q.tei);
				st_d.rsp.valid = 1'b0;
				st_d.fin_due = 1'b0;
			end else if (mg_head_v && !ph_deact_ind) begin
				st_d.tx.valid = 1'b1;
				st_d.tx.frame = ui_frame(SAPI_MGMT, TEI_GROUP,
					mg_head.info);
				mg_pop = 1'b1;
			end else if (l3_head_v && !ph_deact_ind &&
				(l3_head.bcast || st_q.tei_ok)) begin
				st_d.tx.valid = 1'b1;
				if (l3_head.bcast)
					st_d.tx.frame = ui_frame(l3_head.sapi, TEI_GROUP,
						l3_head.info);
				else
					st_d.tx.frame = ui_frame(l3_head.sapi, st_q.tei,
						l3_head.info);
				l3_pop = 1'b1;
			end
		end

		// Response request taken while the holding slot is empty
		if (rsp_req.valid && st_q.rsp_ready)
			st_d.rsp = rsp_req;

		// Received frame handling
		if (rx.valid) begin
			to_us = st_q.tei_ok && (rx.frame.tei == st_q.tei);
			case (rx.kind)
				FK_UI: begin
					if (!rx.cmd) begin
						to_us = 1'b0;
					end else if (rx.frame.sapi == SAPI_MGMT) begin
						if (rx.frame.tei == TEI_GROUP) begin
							st_d.mg_ind.valid = 1'b1;
							st_d.mg_ind.sapi = rx.frame.sapi;
							st_d.mg_ind.info = rx.frame.info;
						end
					end else if ((rx.frame.sapi == SAPI_CALL ||
						rx.frame.sapi == SAPI_PKT) &&
						(rx.frame.tei == TEI_GROUP || to_us)) begin
						st_d.l3_ind.valid = 1'b1;
						st_d.l3_ind.sapi = rx.frame.sapi;
						st_d.l3_ind.info = rx.frame.info;
					end
				end
				FK_SABME, FK_DISC, FK_I, FK_RR, FK_RNR, FK_REJ: begin
					polled = rx.cmd && rx.pf && to_us;
					if (polled) begin
						st_d.fin_due = 1'b1;
						st_d.fin_u = (rx.kind == FK_SABME ||
							rx.kind == FK_DISC);
					end
				end
				FK_FRMR: st_d.frmr_ind = to_us;
				default: polled = 1'b0;
			endcase
		end

		// TEI bookkeeping for establishment and UI requests
		need_tei = est_req || (l3_req.valid && l3_rdy && !l3_req.bcast);
		if (est_req) begin
			if (st_q.tei_ok)
				st_d.est_go = 1'b1;
			else
				st_d.est_pend = 1'b1;
		end
		if (need_tei && !st_q.tei_ok && !st_q.asked) begin
			st_d.assign_ind = 1'b1;
			st_d.asked = 1'b1;
		end
		if (assign_req) begin
			st_d.tei_ok = 1'b1;
			st_d.tei = assign_tei;
			st_d.asked = 1'b0;
			if (st_q.est_pend || (est_req && !st_q.tei_ok)) begin
				st_d.est_go = 1'b1;
				st_d.est_pend = 1'b0;
			end
		end else if (error_rsp) begin
			st_d.asked = 1'b0;
			l3_flush = 1'b1;
			if (st_q.est_pend || (est_req && !st_q.tei_ok)) begin
				st_d.rel_ind = 1'b1;
				st_d.est_pend = 1'b0;
			end
		end else if (remove_req) begin
			st_d.tei_ok = 1'b0;
			st_d.tei = TEI_RST;
			st_d.asked = 1'b0;
		end
		// An assignment in the same cycle as a removal keeps the identifier
		if (remove_req && assign_req)
			st_d.tei_ok = 1'b1;
		st_d.rsp_ready = !st_d.rsp.valid;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			st_q <= '{rsp_ready: 1'b1, tei: TEI_RST, default: '0};
		else
			st_q <= st_d;
	end

	assign l3_req_ready = l3_rdy;
	assign mg_req_ready = mg_rdy;
	assign est_go = st_q.est_go;
	assign rel_ind = st_q.rel_ind;
	assign assign_ind = st_q.assign_ind;
	assign rsp_ready = st_q.rsp_ready;
	assign ph_tx = st_q.tx;
	assign l3_ind = st_q.l3_ind;
	assign mg_ind = st_q.mg_ind;
	assign frmr_ind = st_q.frmr_ind;
	assign final_due = st_q.fin_due;
	assign tei_assigned = st_q.tei_ok;
	assign tei_value = st_q.tei;
endmodule

// ===== verif/ugt_core_props.sv
// Concurrent checks on the ports of the UI frame and TEI gate
`timescale 1ns/1ps
module ugt_core_props (
	input wire logic                 mclk,
	input wire logic                 rst_n,
	input wire ugt_pkg::ugt_ph_t     ph_tx,
	input wire ugt_pkg::ugt_ph_t     ph_rx,
	input wire logic                 ph_deact_ind,
	input wire logic                 assign_req,
	input wire logic [6:0]           assign_tei,
	input wire logic                 tei_assigned,
	input wire logic [6:0]           tei_value,
	input wire logic                 assign_ind,
	input wire ugt_pkg::ugt_ui_ind_t l3_ind,
	input wire ugt_pkg::ugt_ui_ind_t mg_ind
);
	import ugt_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic ui_tx;
	assign ui_tx = ph_tx.valid && (ph_tx.frame.ctl[7:0] & U_PF_MASK) == CTL_UI;

	no_frmr_sent_a: assert property (ph_tx.valid |->
		(ph_tx.frame.ctl[7:0] & U_PF_MASK) != CTL_FRMR)
		else $error("frame reject sent");
	ui_pf_zero_a: assert property (ui_tx |->
		ph_tx.frame.ctl == 16'h0003) else $error("UI with P/F set");
	ui_is_cmd_a: assert property (ui_tx |->
		ph_tx.frame.cr == CR_USER_CMD) else $error("UI not a command");
	mgmt_addr_a: assert property (
		ui_tx && ph_tx.frame.sapi == SAPI_MGMT |->
		ph_tx.frame.tei == TEI_GROUP) else $error("management address");
	rsp_tei_a: assert property (
		ph_tx.valid && ph_tx.frame.ctl[1:0] == S_FMT |->
		ph_tx.frame.tei == tei_value) else $error("response TEI");
	assign_take_a: assert property (assign_req |=> tei_assigned &&
		tei_value == $past(assign_tei)) else $error("assign not taken");
	assign_ind_a: assert property (assign_ind |-> $past(!tei_assigned))
		else $error("assign indication while assigned");
	l3_deliver_a: assert property (l3_ind.valid |-> $past(ph_rx.valid, 2) &&
		$past(ph_rx.frame.cr, 2) == CR_NET_CMD &&
		$past(ph_rx.frame.info, 2) == l3_ind.info) else $error("l3 delivery");
	mg_deliver_a: assert property (mg_ind.valid |->
		$past(ph_rx.frame.sapi, 2) == SAPI_MGMT &&
		$past(ph_rx.frame.tei, 2) == TEI_GROUP) else $error("mgmt delivery");
	deact_flush_a: assert property (ph_deact_ind |=> (!ui_tx)[*2])
		else $error("UI after deactivation");
endmodule

bind ugt_core ugt_core_props i_props (.*);

// ===== verif/ugt_peer.sv
// Peer data link entity and physical layer model
`timescale 1ns/1ps
module ugt_peer (
	input  wire logic             mclk,
	input  wire logic [1:0]       mode,
	input  wire ugt_pkg::ugt_ph_t ph_tx,
	output ugt_pkg::ugt_ph_t      ph_rx,
	output logic                  ph_tx_ready
);
	import ugt_pkg::*;
	ugt_frame_t got[$];
	logic [1:0] cnt = 2'h0;
	initial ph_rx = '0;
	// Takes frames in order, never acknowledges UI
	always @(posedge mclk) begin
		cnt <= cnt + 2'h1;
		if (ph_tx.valid && ph_tx_ready)
			got.push_back(ph_tx.frame);
	end
	// Fast, slow or stalled acceptance
	assign ph_tx_ready = mode == 2'h0 || (mode == 2'h1 && cnt == 2'h3);
	// One cycle frame, then inverted garbage on the line
	task send(input ugt_frame_t f);
		ph_rx = {1'b1, f};
		@(posedge mclk);
		#5;
		ph_rx = {1'b0, ~f};
	endtask
endmodule

// ===== verif/ugt_core_bench.sv
// Self-checking bench of the UI frame and TEI gate
`timescale 1ns/1ps
module ugt_core_bench;
	import ugt_pkg::*;
	logic         mclk = 1'b0;
	logic         rst_n = 1'b0;
	ugt_ui_req_t  l3_req = '0;
	ugt_ui_req_t  mg_req = '0;
	logic         est_req = 1'b0;
	logic         assign_req = 1'b0;
	logic [6:0]   assign_tei = 7'h00;
	logic         remove_req = 1'b0;
	logic         error_rsp = 1'b0;
	ugt_rsp_req_t rsp_req = '0;
	logic         ph_deact_ind = 1'b0;
	logic [1:0]   mode = 2'h0;
	ugt_ph_t      ph_rx, ph_tx;
	logic         ph_tx_ready, l3_req_ready, mg_req_ready, rsp_ready;
	logic         est_go, rel_ind, assign_ind, frmr_ind, final_due;
	logic         tei_assigned;
	logic [6:0]   tei_value;
	ugt_ui_ind_t  l3_ind, mg_ind;
	int           n_errors = 0;
	int           n_checks = 0;
	always #25 mclk = ~mclk;
	ugt_core i_dut (.*);
	ugt_peer i_peer (.*);

	task tick;
		@(posedge mclk);
		#5;
	endtask
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task limit(input logic ok);
		if (!ok) begin
			n_errors++;
			complete_run;
		end
	endtask
	task wait_got(input int n);
		for (int k = 0; k < 200 && i_peer.got.size() < n; k++)
			tick;
		limit(i_peer.got.size() >= n);
	endtask
	function automatic ugt_frame_t ui(logic [5:0] s, logic c, logic [6:0] t,
		logic [7:0] i);
		return {s, c, t, 16'h0003, i};
	endfunction
	// Leaves valid high; caller clears it
	task req(input logic m, input logic b, input logic [5:0] s,
		input logic [7:0] i);
		if (m)
			mg_req = {1'b1, b, s, i};
		else
			l3_req = {1'b1, b, s, i};
		for (int k = 0; k < 100 && !(m ? mg_req_ready : l3_req_ready); k++)
			tick;
		limit(m ? mg_req_ready : l3_req_ready);
		tick;
	endtask
	task rsp(input ugt_rkind_t k);
		rsp_req = {1'b1, k, 7'h03, SAPI_CALL};
		for (int n = 0; n < 50 && !rsp_ready; n++)
			tick;
		limit(rsp_ready);
		tick;
		rsp_req = '0;
		chk(rsp_ready, 1'b0);
	endtask

	task t_assign;
		repeat (3) tick;
		chk(assign_ind, 1'b0);
		est_req = 1'b1;
		tick;
		est_req = 1'b0;
		chk(assign_ind, 1'b1);
		req(1'b0, 1'b0, SAPI_PKT, 8'h77);
		l3_req = '0;
		repeat (4) tick;
		chk(i_peer.got.size(), 0);
		assign_req = 1'b1;
		assign_tei = 7'h05;
		tick;
		assign_req = 1'b0;
		chk({est_go, tei_assigned, tei_value}, {2'h3, 7'h05});
		wait_got(1);
		chk(i_peer.got[0], ui(SAPI_PKT, CR_USER_CMD, 7'h05, 8'h77));
	endtask
	task t_bcast;
		i_peer.got.delete();
		mode = 2'h1;
		for (int k = 0; k < 3; k++)
			req(1'b0, 1'b1, SAPI_CALL, 8'(k + 8'h11));
		l3_req = '0;
		wait_got(3);
		for (int k = 0; k < 3; k++)
			chk(i_peer.got[k], ui(SAPI_CALL, 1'b0, TEI_GROUP, 8'(k + 8'h11)));
		req(1'b1, 1'b0, SAPI_CALL, 8'h5a);
		mg_req = '0;
		wait_got(4);
		chk(i_peer.got[3], ui(SAPI_MGMT, 1'b0, TEI_GROUP, 8'h5a));
		mode = 2'h0;
	endtask
	task t_rx;
		ugt_frame_t f[7];
		logic [1:0] e[7];
		f = '{ui(SAPI_CALL, 1'b1, TEI_GROUP, 8'ha1), ui(SAPI_PKT, 1'b1, 7'h05, 8'ha2),
			ui(SAPI_MGMT, 1'b1, TEI_GROUP, 8'ha3), ui(6'h01, 1'b1, TEI_GROUP, 8'ha4),
			ui(SAPI_CALL, 1'b1, 7'h09, 8'ha5), ui(SAPI_CALL, 1'b0, TEI_GROUP, 8'ha6),
			ui(SAPI_MGMT, 1'b1, 7'h05, 8'ha7)};
		e = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
		for (int k = 0; k < 7; k++) begin
			i_peer.send(f[k]);
			tick;
			chk({l3_ind.valid, mg_ind.valid}, e[k]);
			if (e[k] != 2'h0)
				chk(e[k][1] ? l3_ind.info : mg_ind.info, f[k].info);
		end
	endtask
	task t_poll;
		i_peer.got.delete();
		i_peer.send({SAPI_CALL, 1'b1, 7'h05, 7'h00, 1'b1, CTL_RR, 8'h00});
		tick;
		chk(final_due, 1'b1);
		rsp(RK_UA);
		wait_got(1);
		chk({i_peer.got[0].tei, i_peer.got[0].ctl}, {7'h05, 7'h03, 1'b1, CTL_RR});
		chk(final_due, 1'b0);
		i_peer.send({SAPI_CALL, 1'b1, 7'h05, 16'h007f, 8'h00});
		tick;
		rsp(RK_RR);
		wait_got(2);
		chk(i_peer.got[1].ctl[7:0], CTL_DM | 8'h10);
		rsp(RK_RR);
		wait_got(3);
		chk(i_peer.got[2].ctl[8], 1'b0);
		i_peer.send({SAPI_CALL, 1'b0, 7'h05, 8'h00, CTL_FRMR, 8'h00});
		tick;
		chk(frmr_ind, 1'b1);
	endtask
	task t_deact;
		i_peer.got.delete();
		mode = 2'h2;
		for (int k = 0; k < 5; k++)
			req(1'b0, 1'b1, SAPI_CALL, 8'(k + 8'h31));
		l3_req = '0;
		tick;
		chk(l3_req_ready, 1'b0);
		ph_deact_ind = 1'b1;
		tick;
		ph_deact_ind = 1'b0;
		chk(l3_req_ready, 1'b1);
		mode = 2'h0;
		repeat (20) tick;
		chk(i_peer.got.size(), 0);
		req(1'b0, 1'b1, SAPI_CALL, 8'h44);
		l3_req = '0;
		wait_got(1);
		chk(i_peer.got[0], ui(SAPI_CALL, 1'b0, TEI_GROUP, 8'h44));
	endtask
	task t_error;
		i_peer.got.delete();
		remove_req = 1'b1;
		tick;
		remove_req = 1'b0;
		chk(tei_assigned, 1'b0);
		est_req = 1'b1;
		tick;
		est_req = 1'b0;
		chk(assign_ind, 1'b1);
		req(1'b0, 1'b0, SAPI_CALL, 8'h99);
		l3_req = '0;
		error_rsp = 1'b1;
		tick;
		error_rsp = 1'b0;
		chk(rel_ind, 1'b1);
		assign_req = 1'b1;
		assign_tei = 7'h06;
		tick;
		assign_req = 1'b0;
		repeat (20) tick;
		chk(i_peer.got.size(), 0);
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		#5;
		rst_n = 1'b1;
		t_assign;
		t_bcast;
		t_rx;
		t_poll;
		t_deact;
		t_error;
		complete_run;
	end
	initial begin
		#2000000;
		n_errors++;
		complete_run;
	end
endmodule
